// ---- hw/sffc_af_flow.sv ----
// almost-full with clamps and hysteresis
// assumes fifo empty count, same clock
`timescale 1ns/100ps
`include "sffc_regs.svh"
module sffc_af_flow (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [8:0] i_assert_thr,
  input  wire logic [8:0] i_negate_thr,
  input  wire logic [8:0] i_empty_count,
  output logic            o_almost_full_n
);
  logic [8:0] assert_eff;
  logic [8:0] negate_eff;
  logic       af_r;

  always_comb begin
    assert_eff = i_assert_thr;
    if (i_assert_thr < `SFFC_AF_MIN) assert_eff = `SFFC_AF_MIN;
    if (i_assert_thr > `SFFC_AF_MAX) assert_eff = `SFFC_AF_MAX;
    negate_eff = i_negate_thr;
    if (i_negate_thr < assert_eff)   negate_eff = assert_eff;
    if (i_negate_thr > `SFFC_AF_MAX) negate_eff = `SFFC_AF_MAX;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      af_r <= 1'b0;
    end else if (i_empty_count <= assert_eff) begin
      af_r <= 1'b1;
    end else if (i_empty_count >= negate_eff) begin
      af_r <= 1'b0;
    end
    // holds between thresholds
  end

  assign o_almost_full_n = ~af_r;
endmodule : sffc_af_flow

// ---- hw/sffc_frame_sync.sv ----
// frame loss and regain
// assumes rx word flags on the same clock
`timescale 1ns/100ps
`include "sffc_regs.svh"
module sffc_frame_sync (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_err_limit,
  input  wire logic [3:0] i_train_count,
  input  wire logic       i_word_valid,
  input  wire logic       i_dip4_check,
  input  wire logic       i_dip4_error,
  input  wire logic       i_train_ctrl,
  input  wire logic       i_train_data,
  output logic            o_out_of_frame
);
  sffc_pkg::sffc_sync_e state_r;
  logic [3:0]           err_cnt_r;
  logic [3:0]           word_cnt_r;
  logic [3:0]           pat_cnt_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r    <= sffc_pkg::SYNC_TRAIN_CTRL;
      err_cnt_r  <= 4'h0;
      word_cnt_r <= 4'h0;
      pat_cnt_r  <= 4'h0;
    end else begin
      unique case (state_r)
        sffc_pkg::SYNC_IN_FRAME: begin
          if (i_dip4_check && !i_dip4_error) begin
            err_cnt_r <= 4'h0;
          end else if (i_dip4_check) begin
            if (err_cnt_r + 4'h1 >= i_err_limit) begin
              state_r    <= sffc_pkg::SYNC_TRAIN_CTRL;
              err_cnt_r  <= 4'h0;
              word_cnt_r <= 4'h0;
              pat_cnt_r  <= 4'h0;
            end else begin
              err_cnt_r <= err_cnt_r + 4'h1;
            end
          end
        end
        sffc_pkg::SYNC_TRAIN_CTRL: begin
          if (i_word_valid && i_train_ctrl) begin
            if (word_cnt_r == `SFFC_TRAIN_WORDS) begin
              word_cnt_r <= 4'h0;
              state_r    <= sffc_pkg::SYNC_TRAIN_DATA;
            end else begin
              word_cnt_r <= word_cnt_r + 4'h1;
            end
          end else if (i_word_valid) begin
            word_cnt_r <= 4'h0;
            pat_cnt_r  <= 4'h0;
          end
        end
        sffc_pkg::SYNC_TRAIN_DATA: begin
          // other words break the run
          if (i_word_valid && i_train_data) begin
            if (word_cnt_r == `SFFC_TRAIN_WORDS) begin
              word_cnt_r <= 4'h0;
              if (pat_cnt_r + 4'h1 >= i_train_count) begin
                state_r   <= sffc_pkg::SYNC_IN_FRAME;
                pat_cnt_r <= 4'h0;
                err_cnt_r <= 4'h0;
              end else begin
                pat_cnt_r <= pat_cnt_r + 4'h1;
                state_r   <= sffc_pkg::SYNC_TRAIN_CTRL;
              end
            end else begin
              word_cnt_r <= word_cnt_r + 4'h1;
            end
          end else if (i_word_valid) begin
            word_cnt_r <= 4'h0;
            pat_cnt_r  <= 4'h0;
            state_r    <= sffc_pkg::SYNC_TRAIN_CTRL;
          end
        end
        default: begin
          state_r <= sffc_pkg::SYNC_TRAIN_CTRL;
        end
      endcase
    end
  end

  assign o_out_of_frame = (state_r != sffc_pkg::SYNC_IN_FRAME);
endmodule : sffc_frame_sync

// ---- hw/sffc_sink_cfg.sv ----
// sink frame/flow config: registers, frame state, status
// assumes rx flags and fifo level on i_ref_clk (also status clock);
// calendar memory is outside and answers a lookup
// How it works
// - out-of-frame after limit consecutive parity errors
// - pattern is ten control then ten data
// - regain frame after configured consecutive patterns
// - period setting plus one repetitions per frame
// - length setting plus one entries per sequence
// - calendar settings held on status clock
// - illegal setting replaced by nearest legal value
// - assert threshold clamped to 1..508
// - almost-full when empty count reaches threshold
// - almost-full starts selected flow-control mode
// - mode 00 framing, 01 satisfied, else normal
// - release at negate threshold, resume status
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "sffc_regs.svh"
module sffc_sink_cfg (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_word_valid,
  input  wire logic        i_dip4_check,
  input  wire logic        i_dip4_error,
  input  wire logic        i_train_ctrl,
  input  wire logic        i_train_data,
  input  wire logic [8:0]  i_empty_count,
  input  wire logic [1:0]  i_channel_status,
  output logic      [8:0]  o_cal_index,
  output logic      [1:0]  o_status_channel_out,
  output logic             o_out_of_frame,
  output logic             o_accept_data,
  output logic             o_almost_full_n,
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // register file

  logic                  sink_enable_r;
  sffc_pkg::sffc_af_mode_e almost_full_mode_r;
  logic [3:0]            parity_error_limit_r;
  logic [3:0]            training_pattern_count_r;
  logic [7:0]            calendar_period_setting_r;
  logic [8:0]            calendar_length_setting_r;
  logic [7:0]            period_active_r;
  logic [8:0]            length_active_r;
  logic [8:0]            almost_full_assert_threshold_r;
  logic [8:0]            almost_full_negate_threshold_r;
  logic [3:0]            int_status_r;
  logic [3:0]            int_status_nxt;
  logic [3:0]            int_enable_r;
  logic [3:0]            int_event;
  logic [31:0]           rdata_nxt;
  logic [31:0]           rdata_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sink_enable_r      <= 1'(`SFFC_RST_CTRL >> `SFFC_CTRL_EN_BIT);
      almost_full_mode_r <= sffc_pkg::AF_MODE_OOF;
    end else if (i_wr && i_addr == `SFFC_ADDR_CTRL) begin
      sink_enable_r      <= i_wdata[`SFFC_CTRL_EN_BIT];
      almost_full_mode_r <= sffc_pkg::sffc_af_mode_e'(i_wdata[`SFFC_CTRL_MODE_LSB +: 2]);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      parity_error_limit_r     <= 4'(`SFFC_RST_FRAME_CFG >> `SFFC_FCFG_ERR_LSB);
      training_pattern_count_r <= 4'(`SFFC_RST_FRAME_CFG >> `SFFC_FCFG_TRAIN_LSB);
    end else if (i_wr && i_addr == `SFFC_ADDR_FRAME_CFG) begin
      parity_error_limit_r     <= i_wdata[`SFFC_FCFG_ERR_LSB +: 4];
      training_pattern_count_r <= i_wdata[`SFFC_FCFG_TRAIN_LSB +: 4];
    end
  end

  // writes land any time; sequencer copies
  // only while disabled: no torn setting
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      calendar_period_setting_r <= 8'h00;
      calendar_length_setting_r <= 9'h000;
    end else if (i_wr && i_addr == `SFFC_ADDR_CAL_CFG) begin
      calendar_period_setting_r <= i_wdata[`SFFC_CAL_PERIOD_LSB +: 8];
      calendar_length_setting_r <= i_wdata[`SFFC_CAL_LEN_LSB +: 9];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      period_active_r <= 8'h00;
      length_active_r <= 9'h000;
    end else if (!sink_enable_r) begin
      period_active_r <= calendar_period_setting_r;
      length_active_r <= calendar_length_setting_r;
    end
  end

  // detector lifts negate to assert, so
  // a bad pair cannot oscillate
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      almost_full_assert_threshold_r <= 9'h001;
      almost_full_negate_threshold_r <= `SFFC_AF_MAX;
    end else if (i_wr && i_addr == `SFFC_ADDR_AF_CFG) begin
      almost_full_assert_threshold_r <= i_wdata[`SFFC_AF_ASSERT_LSB +: 9];
      almost_full_negate_threshold_r <= i_wdata[`SFFC_AF_NEGATE_LSB +: 9];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame and almost-full

  logic [3:0] err_limit_eff;
  logic [3:0] train_count_eff;
  logic       sync_oof;
  logic       af_n;
  logic       almost_full;

  assign err_limit_eff   = (parity_error_limit_r == 4'h0) ?
                           `SFFC_LIMIT_MIN : parity_error_limit_r;
  assign train_count_eff = (training_pattern_count_r == 4'h0) ?
                           `SFFC_LIMIT_MIN : training_pattern_count_r;

  sffc_frame_sync u_frame_sync (
    .i_ref_clk      (i_ref_clk),
    .i_rst          (i_rst),
    .i_err_limit    (err_limit_eff),
    .i_train_count  (train_count_eff),
    .i_word_valid   (i_word_valid),
    .i_dip4_check   (i_dip4_check),
    .i_dip4_error   (i_dip4_error),
    .i_train_ctrl   (i_train_ctrl),
    .i_train_data   (i_train_data),
    .o_out_of_frame (sync_oof)
  );

  sffc_af_flow u_af_flow (
    .i_ref_clk       (i_ref_clk),
    .i_rst           (i_rst),
    .i_assert_thr    (almost_full_assert_threshold_r),
    .i_negate_thr    (almost_full_negate_threshold_r),
    .i_empty_count   (i_empty_count),
    .o_almost_full_n (af_n)
  );

  assign almost_full = ~af_n;

  logic force_oof;
  logic force_sat;
  logic oof_now;
  logic oof_prev_r;
  logic af_prev_r;

  assign force_oof = almost_full && almost_full_mode_r == sffc_pkg::AF_MODE_OOF;
  assign force_sat = almost_full && almost_full_mode_r == sffc_pkg::AF_MODE_SAT;
  assign oof_now   = sync_oof | force_oof;

  assign o_out_of_frame  = oof_now;
  assign o_accept_data   = ~oof_now;
  assign o_almost_full_n = af_n;

  ////////////////////////////////////////////////////////////////////////
  // status sequencer

  sffc_pkg::sffc_seq_e seq_r;
  logic [8:0]          entry_r;
  logic [7:0]          rep_r;
  logic [1:0]          dip_r;
  logic [1:0]          stat_r;
  logic [1:0]          entry_stat;

  // simplified parity: running xor of
  // sent pairs, folded alike at both ends
  assign entry_stat = force_sat ? 2'b10 : i_channel_status;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      seq_r   <= sffc_pkg::SEQ_IDLE;
      entry_r <= 9'h000;
      rep_r   <= 8'h00;
    end else if (!sink_enable_r || force_oof) begin
      // mode 00 holds framing
      seq_r   <= sink_enable_r ? sffc_pkg::SEQ_FRAME : sffc_pkg::SEQ_IDLE;
      entry_r <= 9'h000;
      rep_r   <= 8'h00;
    end else begin
      unique case (seq_r)
        sffc_pkg::SEQ_IDLE: begin
          seq_r <= sffc_pkg::SEQ_FRAME;
        end
        sffc_pkg::SEQ_FRAME: begin
          seq_r   <= sffc_pkg::SEQ_ENTRY;
          entry_r <= 9'h000;
          rep_r   <= 8'h00;
        end
        sffc_pkg::SEQ_ENTRY: begin
          if (entry_r == length_active_r) begin
            entry_r <= 9'h000;
            if (rep_r == period_active_r) begin
              seq_r <= sffc_pkg::SEQ_DIP2;
            end else begin
              rep_r <= rep_r + 8'h01;
            end
          end else begin
            entry_r <= entry_r + 9'h001;
          end
        end
        sffc_pkg::SEQ_DIP2: begin
          seq_r <= sffc_pkg::SEQ_FRAME;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dip_r <= 2'b00;
    end else if (seq_r == sffc_pkg::SEQ_ENTRY && !force_oof) begin
      dip_r <= dip_r ^ entry_stat;
    end else if (seq_r != sffc_pkg::SEQ_ENTRY) begin
      dip_r <= 2'b00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      stat_r <= 2'b11;
    end else if (force_oof || seq_r == sffc_pkg::SEQ_IDLE) begin
      stat_r <= 2'b11;
    end else begin
      unique case (seq_r)
        sffc_pkg::SEQ_FRAME: stat_r <= 2'b11;
        sffc_pkg::SEQ_ENTRY: stat_r <= entry_stat;
        sffc_pkg::SEQ_DIP2:  stat_r <= dip_r;
        default:             stat_r <= 2'b11;
      endcase
    end
  end

  assign o_cal_index          = entry_r;
  assign o_status_channel_out = stat_r;

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      oof_prev_r <= 1'b1;
      af_prev_r  <= 1'b0;
    end else begin
      oof_prev_r <= oof_now;
      af_prev_r  <= almost_full;
    end
  end

  always_comb begin
    int_event = 4'h0;
    int_event[`SFFC_INT_OOF_BIT]     = oof_now & ~oof_prev_r;
    int_event[`SFFC_INT_INFRAME_BIT] = ~oof_now & oof_prev_r;
    int_event[`SFFC_INT_AF_BIT]      = almost_full & ~af_prev_r;
    int_event[`SFFC_INT_AF_CLR_BIT]  = ~almost_full & af_prev_r;
  end

  // set wins over clear
  always_comb begin
    int_status_nxt = int_status_r;
    if (i_wr && i_addr == `SFFC_ADDR_INT_CLEAR) begin
      int_status_nxt = int_status_r & ~i_wdata[3:0];
    end
    int_status_nxt = int_status_nxt | int_event;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      int_status_r <= 4'h0;
    end else begin
      int_status_r <= int_status_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      int_enable_r <= 4'h0;
    end else if (i_wr && i_addr == `SFFC_ADDR_INT_ENABLE) begin
      int_enable_r <= i_wdata[3:0];
    end
  end

  assign o_irq = |(int_status_r & int_enable_r);

  ////////////////////////////////////////////////////////////////////////
  // read port: data for one cycle

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (i_addr)
      `SFFC_ADDR_CTRL: begin
        rdata_nxt[`SFFC_CTRL_EN_BIT]        = sink_enable_r;
        rdata_nxt[`SFFC_CTRL_MODE_LSB +: 2] = almost_full_mode_r;
      end
      `SFFC_ADDR_FRAME_CFG: begin
        rdata_nxt[`SFFC_FCFG_ERR_LSB +: 4]   = parity_error_limit_r;
        rdata_nxt[`SFFC_FCFG_TRAIN_LSB +: 4] = training_pattern_count_r;
      end
      `SFFC_ADDR_CAL_CFG: begin
        rdata_nxt[`SFFC_CAL_PERIOD_LSB +: 8] = calendar_period_setting_r;
        rdata_nxt[`SFFC_CAL_LEN_LSB +: 9]    = calendar_length_setting_r;
      end
      `SFFC_ADDR_AF_CFG: begin
        rdata_nxt[`SFFC_AF_ASSERT_LSB +: 9] = almost_full_assert_threshold_r;
        rdata_nxt[`SFFC_AF_NEGATE_LSB +: 9] = almost_full_negate_threshold_r;
      end
      `SFFC_ADDR_STATUS: begin
        rdata_nxt[0]     = oof_now;
        rdata_nxt[1]     = almost_full;
        rdata_nxt[3:2]   = seq_r;
        rdata_nxt[24:16] = i_empty_count;
      end
      `SFFC_ADDR_INT_STATUS: rdata_nxt[3:0] = int_status_r;
      `SFFC_ADDR_INT_ENABLE: rdata_nxt[3:0] = int_enable_r;
      default:               rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign o_rdata = rdata_r;

endmodule : sffc_sink_cfg

// ---- include/sffc_pkg.sv ----
// types shared by the sink frame and flow-control block
// assumes sffc_regs.svh for numeric constants
package sffc_pkg;

  typedef enum logic [1:0] {
    AF_MODE_OOF   = 2'b00,
    AF_MODE_SAT   = 2'b01,
    AF_MODE_NORM0 = 2'b10,
    AF_MODE_NORM1 = 2'b11
  } sffc_af_mode_e;

  typedef enum logic [1:0] {
    SYNC_IN_FRAME   = 2'b00,
    SYNC_TRAIN_CTRL = 2'b01,
    SYNC_TRAIN_DATA = 2'b10
  } sffc_sync_e;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_FRAME = 2'b01,
    SEQ_ENTRY = 2'b10,
    SEQ_DIP2  = 2'b11
  } sffc_seq_e;

endpackage : sffc_pkg

// ---- include/sffc_regs.svh ----
// register offsets, field positions, reset values and fixed counts
// assumes byte-addressed register port with 8-bit addresses
`ifndef SFFC_REGS_SVH
`define SFFC_REGS_SVH

`define SFFC_ADDR_CTRL        8'h00
`define SFFC_ADDR_FRAME_CFG   8'h04
`define SFFC_ADDR_CAL_CFG     8'h08
`define SFFC_ADDR_AF_CFG      8'h0c
`define SFFC_ADDR_STATUS      8'h10
`define SFFC_ADDR_INT_STATUS  8'h14
`define SFFC_ADDR_INT_CLEAR   8'h18
`define SFFC_ADDR_INT_ENABLE  8'h1c

`define SFFC_CTRL_EN_BIT      0
`define SFFC_CTRL_MODE_LSB    1
`define SFFC_FCFG_ERR_LSB     0
`define SFFC_FCFG_TRAIN_LSB   4
`define SFFC_CAL_PERIOD_LSB   0
`define SFFC_CAL_LEN_LSB      16
`define SFFC_AF_ASSERT_LSB    0
`define SFFC_AF_NEGATE_LSB    16

`define SFFC_INT_OOF_BIT      0
`define SFFC_INT_INFRAME_BIT  1
`define SFFC_INT_AF_BIT       2
`define SFFC_INT_AF_CLR_BIT   3

`define SFFC_RST_CTRL         32'h0000_0000
`define SFFC_RST_FRAME_CFG    32'h0000_0011
`define SFFC_RST_CAL_CFG      32'h0000_0000
`define SFFC_RST_AF_CFG       32'h01fc_0001

`define SFFC_TRAIN_WORDS      4'h9
`define SFFC_AF_MAX           9'h1fc
`define SFFC_AF_MIN           9'h001
`define SFFC_LIMIT_MIN        4'h1

`endif

// ---- testbench/sffc_sink_props.sv ----
// port checks for the sink config block
// assumes one clock, sync active-high reset
`timescale 1ns/100ps
module sffc_sink_props (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_word_valid,
  input wire logic        i_dip4_check,
  input wire logic        i_dip4_error,
  input wire logic        i_train_data,
  input wire logic [8:0]  i_empty_count,
  input wire logic        o_out_of_frame,
  input wire logic        o_accept_data,
  input wire logic        o_almost_full_n
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  // clamped thresholds always cover these counts
  sequence af_low_s; i_empty_count <= 9'h001; endsequence
  sequence af_high_s; i_empty_count > 9'h1fc; endsequence
  accept_inv_a: assert property (
    o_accept_data == !o_out_of_frame) else $error("accept not inverse of frame");
  af_set_a: assert property (
    af_low_s |=> !o_almost_full_n) else $error("almost full missed at minimum");
  af_clear_a: assert property (
    af_high_s |=> o_almost_full_n) else $error("almost full held above maximum");
  af_fall_cause_a: assert property (
    $fell(o_almost_full_n) |-> $past(i_empty_count) <= 9'h1fc)
    else $error("almost full set above maximum");
  af_rise_cause_a: assert property (
    $rose(o_almost_full_n) |-> $past(i_empty_count) > 9'h001)
    else $error("almost full released at minimum");
  oof_rise_cause_a: assert property (
    $rose(o_out_of_frame) |-> $past(i_dip4_check && i_dip4_error) || !o_almost_full_n
      || $past(i_wr)) else $error("frame lost without cause");
  oof_fall_cause_a: assert property (
    $fell(o_out_of_frame) |-> $past(i_word_valid && i_train_data) || $rose(o_almost_full_n)
      || $past(i_wr)) else $error("frame gained without cause");
  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside read slot");
endmodule : sffc_sink_props

bind sffc_sink_cfg sffc_sink_props chk_u (.i_ref_clk, .i_rst, .i_wr, .i_rd, .o_rdata,
  .i_word_valid, .i_dip4_check, .i_dip4_error, .i_train_data, .i_empty_count,
  .o_out_of_frame, .o_accept_data, .o_almost_full_n);

// ---- testbench/sffc_tx_model.sv ----
// far-side transmitter: checked words, training
// assumes go only while idle
`timescale 1ns/100ps
module sffc_tx_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_go,
  input  wire logic [1:0] i_cmd,
  input  wire logic [8:0] i_cal_index,
  output logic            o_busy,
  output logic            o_word_valid,
  output logic            o_dip4_check,
  output logic            o_dip4_error,
  output logic            o_train_ctrl,
  output logic            o_train_data,
  output logic [1:0]      o_channel_status
);
  // cmd 0 good, 1 bad parity, 2 pattern, 3 pattern short one ctrl
  logic [4:0] pos_r;
  logic [1:0] cmd_r;
  logic       junk_r;
  logic       pat_w;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk) begin
    junk_r <= i_rst ? 1'b0 : !junk_r;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else if (i_go && !o_busy) begin
      o_busy <= 1'b1;
      cmd_r  <= i_cmd;
      pos_r  <= {4'h0, i_cmd == 2'b11};
    end else if (o_busy) begin
      pos_r <= pos_r + 5'h01;
      if (!cmd_r[1] || pos_r == 5'h13) begin
        o_busy <= 1'b0;
      end
    end
  end
  assign pat_w            = o_busy && cmd_r[1];
  assign o_word_valid     = o_busy;
  assign o_dip4_check     = o_busy && !cmd_r[1];
  // idle flags toggle: never look steady
  assign o_dip4_error     = o_dip4_check ? cmd_r[0] : junk_r;
  assign o_train_ctrl     = pat_w ? (pos_r < 5'h0a) : (!o_busy && junk_r);
  assign o_train_data     = pat_w ? (pos_r >= 5'h0a) : (!o_busy && junk_r);
  // same-cycle lookup, status from index
  assign o_channel_status = {i_cal_index[0], i_cal_index[1]};
endmodule : sffc_tx_model

// ---- testbench/tb.sv ----
// self-checking bench, sink config block
// assumes tx model and bound checker
`timescale 1ns/100ps
`include "sffc_regs.svh"
module tb;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [8:0]  i_empty_count = 9'h100;
  logic        go = 1'b0;
  logic [1:0]  cmd = 2'b00;
  logic        busy, word_valid, dip4_check, dip4_error, train_ctrl, train_data, irq;
  logic [1:0]  chan_status, status;
  logic [8:0]  cal_index;
  logic [31:0] rdata;
  logic        oof, accept, af_n;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cycles = 0;
  localparam logic [7:0]  RA [7] = '{`SFFC_ADDR_CTRL, `SFFC_ADDR_FRAME_CFG, `SFFC_ADDR_CAL_CFG,
    `SFFC_ADDR_AF_CFG, `SFFC_ADDR_INT_CLEAR, `SFFC_ADDR_INT_ENABLE, 8'h20};
  localparam logic [31:0] RV [7] = '{32'h0, 32'h11, 32'h0, 32'h01fc_0001, 32'h0, 32'h0, 32'h0};

  always #5 i_ref_clk = ~i_ref_clk;

  sffc_sink_cfg dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_word_valid(word_valid),
    .i_dip4_check(dip4_check), .i_dip4_error(dip4_error), .i_train_ctrl(train_ctrl),
    .i_train_data(train_data), .i_empty_count(i_empty_count), .i_channel_status(chan_status),
    .o_cal_index(cal_index), .o_status_channel_out(status), .o_out_of_frame(oof),
    .o_accept_data(accept), .o_almost_full_n(af_n), .o_irq(irq));
  sffc_tx_model tx_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_go(go), .i_cmd(cmd),
    .i_cal_index(cal_index), .o_busy(busy), .o_word_valid(word_valid),
    .o_dip4_check(dip4_check), .o_dip4_error(dip4_error), .o_train_ctrl(train_ctrl),
    .o_train_data(train_data), .o_channel_status(chan_status));
  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // returns once the model is idle
  task automatic send(input logic [1:0] c);
    int k = 0;
    @(posedge i_ref_clk);
    go  <= 1'b1;
    cmd <= c;
    @(posedge i_ref_clk);
    go <= 1'b0;
    #1;
    while (busy === 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
  endtask : send
  task automatic af_step(input logic [8:0] c, input logic e);
    @(posedge i_ref_clk);
    i_empty_count <= c;
    tick(3);
    chk("almost_full_n", {31'h0, e}, af_n);
  endtask : af_step
  // skip framing, compare from first entry
  task automatic seq_check(input int n, input logic [31:0] pat);
    int k = 0;
    while (status !== 2'b11 && k < 60) begin
      tick(1);
      k++;
    end
    while (status === 2'b11 && k < 60) begin
      tick(1);
      k++;
    end
    for (int i = 0; i < n; i++) begin
      chk("status_seq", pat[2*i +: 2], status);
      tick(1);
    end
  endtask : seq_check
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    wr(8'h20, 32'hffff_ffff);
    for (int i = 0; i < 7; i++) begin
      rd(RA[i], d);
      chk("reg_reset", RV[i], d);
    end
    chk("oof", 1, oof);
    chk("af_n", 1, af_n);
    chk("status", 2'b11, status);
    chk("irq", 0, irq);
  endtask : t_regs
  task automatic t_train;
    logic [31:0] d;
    wr(`SFFC_ADDR_INT_CLEAR, 32'hf);
    wr(`SFFC_ADDR_INT_ENABLE, 32'h2);
    wr(`SFFC_ADDR_FRAME_CFG, 32'h23);
    send(2'd2);
    chk("oof", 1, oof);
    send(2'd3);
    chk("oof", 1, oof);
    send(2'd2);
    chk("oof", 1, oof);
    send(2'd2);
    chk("oof", 0, oof);
    chk("accept", 1, accept);
    tick(2);
    chk("irq", 1, irq);
    rd(`SFFC_ADDR_INT_STATUS, d);
    chk("int_status", 32'h2, d & 32'h2);
    wr(`SFFC_ADDR_INT_CLEAR, 32'h2);
    tick(2);
    chk("irq", 0, irq);
  endtask : t_train
  task automatic t_parity;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) send(i == 2 ? 2'd0 : 2'd1);
    chk("oof", 0, oof);
    send(2'd1);
    chk("oof", 1, oof);
    tick(2);
    chk("irq", 0, irq);
    rd(`SFFC_ADDR_INT_STATUS, d);
    chk("int_status", 32'h1, d & 32'h1);
    wr(`SFFC_ADDR_FRAME_CFG, 32'h00);
    send(2'd2);
    chk("oof", 0, oof);
    send(2'd1);
    chk("oof", 1, oof);
  endtask : t_parity
  task automatic t_af;
    logic [31:0] d;
    wr(`SFFC_ADDR_AF_CFG, 32'h01ff_0000);
    af_step(9'h002, 1'b1);
    af_step(9'h001, 1'b0);
    af_step(9'h1fb, 1'b0);
    af_step(9'h1fc, 1'b1);
    wr(`SFFC_ADDR_AF_CFG, 32'h0005_01ff);
    af_step(9'h1fd, 1'b1);
    af_step(9'h1fc, 1'b0);
    af_step(9'h1fd, 1'b1);
    wr(`SFFC_ADDR_AF_CFG, 32'h0014_000a);
    af_step(9'h00b, 1'b1);
    af_step(9'h00a, 1'b0);
    af_step(9'h013, 1'b0);
    af_step(9'h014, 1'b1);
    rd(`SFFC_ADDR_INT_STATUS, d);
    chk("int_status", 32'hc, d & 32'hc);
  endtask : t_af
  task automatic t_cal;
    send(2'd2);
    wr(`SFFC_ADDR_CTRL, 32'h0);
    wr(`SFFC_ADDR_CAL_CFG, 32'h0002_0001);
    wr(`SFFC_ADDR_CTRL, 32'h5);
    seq_check(8, 32'hc618);
    wr(`SFFC_ADDR_CTRL, 32'h0);
    wr(`SFFC_ADDR_CAL_CFG, 32'h0001_0000);
    wr(`SFFC_ADDR_CTRL, 32'h5);
    seq_check(4, 32'he8);
  endtask : t_cal
  task automatic t_mode;
    int   n11, n01, n00, noof;
    logic ok;
    wr(`SFFC_ADDR_CTRL, 32'h0);
    wr(`SFFC_ADDR_CAL_CFG, 32'h0002_0000);
    wr(`SFFC_ADDR_AF_CFG, 32'h0014_000a);
    @(posedge i_ref_clk);
    i_empty_count <= 9'h005;
    for (int m = 0; m < 3; m++) begin
      wr(`SFFC_ADDR_CTRL, {29'h0, m[1:0], 1'b1});
      tick(3);
      {n11, n01, n00, noof} = '0;
      repeat (16) begin
        n11  += int'(status === 2'b11);
        n01  += int'(status === 2'b01);
        n00  += int'(status === 2'b00);
        noof += int'(oof === 1'b1);
        tick(1);
      end
      ok = (m == 0) ? (n11 == 16 && noof == 16) :
           (m == 1) ? (n01 + n00 == 0 && noof == 0) : (n01 > 0 && noof == 0);
      chk("af_mode", 1, ok);
    end
    @(posedge i_ref_clk);
    i_empty_count <= 9'h01e;
    wr(`SFFC_ADDR_CTRL, 32'h1);
    tick(3);
    chk("oof", 0, oof);
    chk("af_n", 1, af_n);
  endtask : t_mode
  ////////////////////////////////////////////////////////////
  // run needs a few hundred cycles
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_regs();
    t_train();
    t_parity();
    t_af();
    t_cal();
    t_mode();
    complete_run();
  end
endmodule : tb
